// [cic_top.sv]
// Interrupt controller of an 8-bit CPU core: latching, priority, entry, wake-up
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Maskable requests serviced only with mask clear
// - Masked requests stay latched until mask clears
// - Reset leaves global mask set
// - Entry only at instruction boundary
// - Push program counter, index, accumulator, condition codes
// - Entry sets the global mask
// - Load program counter from selected vector
// - Interrupt return restores stacked mask
// - Fixed priority: reset, trap, vectors ascending
// - Trap entered regardless of mask
// - Any request wakes from wait
// - Only designated sources wake from halt
// - Overflow and timebase one wake active-halt
// - Auto wake-up exits wait and wake-from-halt modes only
// - Fixed vector addresses, two bytes apart
// - Edge latch cleared on handler entry
// - Sensitivity applies to selected external line
// - Peripheral request needs enable and clear mask
// - Clear sequence discards pending latch
// - Supply flag rise raises request, auto-cleared
module cic_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Core status and commands
    input  wire logic        instr_end,
    input  wire logic        trap_exec,
    input  wire logic        interrupt_return_exec,
    input  wire logic [7:0]  cc_pop,
    input  wire logic        mask_set,
    input  wire logic        mask_clr,
    input  wire logic [2:0]  power_mode,
    input  wire logic [15:0] cpu_pc,
    input  wire logic [7:0]  cpu_x,
    input  wire logic [7:0]  cpu_a,
    input  wire logic [7:0]  cpu_cc,
    // Core control
    output logic             cpu_hold,
    output logic             global_mask,
    output logic             wake_req,
    // Stack and vector memory
    output logic             stack_push,
    output logic      [7:0]  stack_data,
    output logic             vec_rd,
    output logic      [15:0] vec_addr,
    input  wire logic [7:0]  vec_rdata,
    output logic             pc_load,
    output logic      [15:0] pc_value,
    // Interrupt sources
    input  wire logic [3:0]  external_irq_line,
    input  wire logic        supply_monitor_flag,
    input  wire logic [13:0] periph_flag,
    input  wire logic [13:0] periph_clr
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        cic_pkg::cic_fsm_t fsm;
        logic              i_mask;
        logic              trap_pend;
        logic [3:0]        ext_lat;
        logic [3:0]        ext_prev;
        logic              sup_lat;
        logic              sup_prev;
        logic [13:0]       per_lat;
        logic [13:0]       per_prev;
        logic [13:0]       enable;
        logic [7:0]        sense;
        logic              is_trap;
        logic [3:0]        vec;
        logic [15:0]       pc_save;
        logic [7:0]        x_save;
        logic [7:0]        a_save;
        logic [7:0]        cc_save;
        logic [7:0]        vec_hi;
        logic              hold;
        logic              push;
        logic [7:0]        push_data;
        logic              mrd;
        logic [15:0]       maddr;
        logic              load;
        logic [15:0]       pc_val;
        logic              wake;
        logic [15:0]       rdata;
    } cic_state_t;

    cic_state_t st_reg;
    cic_state_t st_next;

    // ========================================================================
    // Functions
    // ========================================================================
    // Vector n sits two bytes below vector n-1
    function automatic logic [15:0] vector_of(input logic trap, input logic [3:0] n);
        logic [15:0] off;
        off = {11'h000, n, 1'b0};
        if (trap)
            vector_of = cic_pkg::TRAP_VEC;
        else
            vector_of = cic_pkg::VEC0_ADDR - off;
    endfunction : vector_of

    // Lowest vector number wins
    function automatic logic [3:0] first_set(input logic [13:0] v);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = cic_pkg::NUM_VEC - 1; i >= 0; i--)
            if (v[i])
                idx = i[3:0];
        first_set = idx;
    endfunction : first_set

    // Edge detection for one external line; the mode 00 low level is added outside
    function automatic logic ext_edge(input logic [1:0] s, input logic cur, input logic prv);
        case (s)
            cic_pkg::SENS_RISE:     ext_edge = cur & ~prv;
            cic_pkg::SENS_FALL:     ext_edge = ~cur & prv;
            cic_pkg::SENS_BOTH:     ext_edge = cur ^ prv;
            cic_pkg::SENS_FALL_LOW: ext_edge = ~cur & prv;
            default:                ext_edge = 1'b0;
        endcase
    endfunction : ext_edge

    // Vector number of external line i
    function automatic logic [3:0] vec_ext_idx(input int i);
        vec_ext_idx = cic_pkg::VEC_EXT0 + i[3:0];
    endfunction : vec_ext_idx

    // ========================================================================
    // Request combination
    // ========================================================================
    logic [3:0]  ext_set;
    logic [3:0]  ext_req;
    logic [13:0] req_raw;
    logic [13:0] req_ok;
    logic [13:0] wake_elig;
    logic        take;

    // Low level in mode 00 requests without latching, as long as held
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            ext_set[i] = ext_edge(st_reg.sense[2*i +: 2], external_irq_line[i],
                                  st_reg.ext_prev[i]);
            ext_req[i] = st_reg.ext_lat[i]
                       | ((st_reg.sense[2*i +: 2] == cic_pkg::SENS_FALL_LOW)
                          & ~external_irq_line[i]);
        end
    end

    // Pending requests, flag sources gated by enable, before and after the global mask
    always_comb
    begin
        req_raw = (st_reg.per_lat & st_reg.enable & cic_pkg::PER_MASK)
                | {9'h000, ext_req, 1'b0}
                | {6'h00, st_reg.sup_lat, 7'h00};
        req_raw = req_raw & cic_pkg::VEC_USED_MASK;
        req_ok  = req_raw & {14{~st_reg.i_mask}};
        take    = (st_reg.fsm == cic_pkg::CIC_IDLE) & instr_end
                & (st_reg.trap_pend | trap_exec | (|req_ok));
    end

    // Sources allowed to end each low-power mode
    always_comb
    begin
        case (power_mode)
            cic_pkg::CIC_WAIT:  wake_elig = cic_pkg::VEC_USED_MASK;
            cic_pkg::CIC_HALT:  wake_elig = cic_pkg::WAKE_HALT;
            cic_pkg::CIC_AHALT: wake_elig = cic_pkg::WAKE_AHALT;
            cic_pkg::CIC_WAKEUP_FROM_HALT_MODE: wake_elig = cic_pkg::WAKE_WAKEUP_FROM_HALT_MODE;
            default:            wake_elig = 14'h0000;
        endcase
    end

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb
    begin
        st_next           = st_reg;
        st_next.push      = 1'b0;
        st_next.mrd       = 1'b0;
        st_next.load      = 1'b0;
        st_next.rdata     = 16'h0000;
        st_next.ext_prev  = external_irq_line;
        st_next.sup_prev  = supply_monitor_flag;
        st_next.per_prev  = periph_flag;
        // Wake on any pending request eligible in the current power mode, flag sources only when enabled; mask is irrelevant here
        st_next.wake      = |(req_raw & wake_elig);

        // Latches: hardware set wins over any clear in the same cycle
        st_next.ext_lat   = st_reg.ext_lat | ext_set;
        st_next.per_lat   = (st_reg.per_lat & ~periph_clr)
                          | (periph_flag & ~st_reg.per_prev & cic_pkg::PER_MASK);
        st_next.trap_pend = st_reg.trap_pend | trap_exec;

        // Core mask instructions; interrupt_return restores the stacked copy
        if (mask_set)
            st_next.i_mask = 1'b1;
        else if (mask_clr)
            st_next.i_mask = 1'b0;
        else if (interrupt_return_exec)
            st_next.i_mask = cc_pop[cic_pkg::CC_I_BIT];

        // Register writes; sensitivity may change only while masked
        if (reg_wr)
        begin
            case (reg_addr)
                // Supply enable rides in bit 7 beside the flag-source enables
                cic_pkg::REG_ENABLE: st_next.enable = reg_wdata[13:0]
                    & (cic_pkg::PER_MASK | (14'h0001 << cic_pkg::VEC_SUPPLY));
                cic_pkg::REG_SENSE:
                begin
                    if (st_reg.i_mask)
                        st_next.sense = reg_wdata[7:0];
                end
                default: ;
            endcase
        end

        // Register reads, valid the cycle after the strobe only
        if (reg_rd)
        begin
            case (reg_addr)
                cic_pkg::REG_ENABLE:  st_next.rdata = {2'h0, st_reg.enable};
                cic_pkg::REG_SENSE:   st_next.rdata = {8'h00, st_reg.sense};
                cic_pkg::REG_PENDING: st_next.rdata = {2'h0, req_raw};
                cic_pkg::REG_STATUS:  st_next.rdata = {7'h00, st_reg.is_trap,
                                                       st_reg.vec, 2'h0,
                                                       st_reg.hold, st_reg.i_mask};
                default:              st_next.rdata = 16'h0000;
            endcase
        end

        // Entry sequencer
        case (st_reg.fsm)
            cic_pkg::CIC_IDLE:
            begin
                if (take)
                begin
                    st_next.hold    = 1'b1;
                    st_next.pc_save = cpu_pc;
                    st_next.x_save  = cpu_x;
                    st_next.a_save  = cpu_a;
                    st_next.cc_save = cpu_cc;
                    st_next.cc_save[cic_pkg::CC_I_BIT] = st_reg.i_mask;
                    st_next.fsm     = cic_pkg::CIC_PUSH_PL;
                    if (st_reg.trap_pend | trap_exec)
                    begin
                        st_next.is_trap   = 1'b1;
                        st_next.trap_pend = 1'b0;
                        st_next.vec       = 4'h0;
                    end
                    else
                    begin
                        st_next.is_trap = 1'b0;
                        st_next.vec     = first_set(req_ok);
                        // Edge latches and the supply request clear on entry
                        for (int i = 0; i < 4; i++)
                            if (first_set(req_ok) == vec_ext_idx(i))
                                st_next.ext_lat[i] = ext_set[i];
                        if (first_set(req_ok) == cic_pkg::VEC_SUPPLY)
                            st_next.sup_lat = 1'b0;
                    end
                    st_next.i_mask = 1'b1;
                end
            end
            cic_pkg::CIC_PUSH_PL:
            begin
                st_next.push      = 1'b1;
                st_next.push_data = st_reg.pc_save[7:0];
                st_next.fsm       = cic_pkg::CIC_PUSH_PH;
            end
            cic_pkg::CIC_PUSH_PH:
            begin
                st_next.push      = 1'b1;
                st_next.push_data = st_reg.pc_save[15:8];
                st_next.fsm       = cic_pkg::CIC_PUSH_X;
            end
            cic_pkg::CIC_PUSH_X:
            begin
                st_next.push      = 1'b1;
                st_next.push_data = st_reg.x_save;
                st_next.fsm       = cic_pkg::CIC_PUSH_A;
            end
            cic_pkg::CIC_PUSH_A:
            begin
                st_next.push      = 1'b1;
                st_next.push_data = st_reg.a_save;
                st_next.fsm       = cic_pkg::CIC_PUSH_CC;
            end
            cic_pkg::CIC_PUSH_CC:
            begin
                st_next.push      = 1'b1;
                st_next.push_data = st_reg.cc_save;
                st_next.fsm       = cic_pkg::CIC_VEC_HI;
            end
            cic_pkg::CIC_VEC_HI:
            begin
                st_next.mrd   = 1'b1;
                st_next.maddr = vector_of(st_reg.is_trap, st_reg.vec);
                st_next.fsm   = cic_pkg::CIC_VEC_LO;
            end
            cic_pkg::CIC_VEC_LO:
            begin
                st_next.mrd   = 1'b1;
                st_next.maddr = vector_of(st_reg.is_trap, st_reg.vec) + 16'h0001;
                st_next.fsm   = cic_pkg::CIC_GET_LO;
            end
            cic_pkg::CIC_GET_LO:
            begin
                // High byte answers the first read
                st_next.vec_hi = vec_rdata;
                st_next.fsm    = cic_pkg::CIC_LOAD;
            end
            cic_pkg::CIC_LOAD:
            begin
                st_next.load   = 1'b1;
                st_next.pc_val = {st_reg.vec_hi, vec_rdata};
                st_next.hold   = 1'b0;
                st_next.fsm    = cic_pkg::CIC_IDLE;
            end
            default:
                st_next.fsm = cic_pkg::CIC_IDLE;
        endcase

        // Supply monitor: rise with enable set; a new rise beats the entry clear
        if (supply_monitor_flag & ~st_reg.sup_prev & st_reg.enable[cic_pkg::VEC_SUPPLY])
            st_next.sup_lat = 1'b1;
    end

    // ========================================================================
    // Registers
    // ========================================================================
    // Reset leaves every source masked and all latches empty
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            st_reg        <= '0;
            st_reg.fsm    <= cic_pkg::CIC_IDLE;
            st_reg.i_mask <= 1'b1;
            st_reg.enable <= cic_pkg::ENABLE_RST;
            st_reg.sense  <= cic_pkg::SENSE_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ========================================================================
    // Outputs, all straight from the state flops
    // ========================================================================
    assign reg_rdata   = st_reg.rdata;
    assign cpu_hold    = st_reg.hold;
    assign global_mask = st_reg.i_mask;
    assign wake_req    = st_reg.wake;
    assign stack_push  = st_reg.push;
    assign stack_data  = st_reg.push_data;
    assign vec_rd      = st_reg.mrd;
    assign vec_addr    = st_reg.maddr;
    assign pc_load     = st_reg.load;
    assign pc_value    = st_reg.pc_val;

endmodule : cic_top

`default_nettype wire

// [cic_pkg.sv]
// Shared constants and types of the CPU interrupt controller
package cic_pkg;

    // ========================================================================
    // Sources and vectors
    // ========================================================================
    localparam int          NUM_VEC       = 14;
    localparam logic [13:0] VEC_USED_MASK = 14'h1FBF;   // Slots 6 and 13 unused
    localparam logic [13:0] PER_MASK      = 14'h1F21;   // Flag/enable sources
    localparam logic [3:0]  VEC_EXT0      = 4'h1;       // First external line
    localparam logic [3:0]  VEC_SUPPLY    = 4'h7;
    localparam logic [15:0] RESET_VEC     = 16'hFFFE;
    localparam logic [15:0] TRAP_VEC      = 16'hFFFC;
    localparam logic [15:0] VEC0_ADDR     = 16'hFFFA;

    // ========================================================================
    // Wake-up eligibility per low-power mode
    // ========================================================================
    localparam logic [13:0] WAKE_HALT     = 14'h101E;   // Ext lines and serial port
    localparam logic [13:0] WAKE_WAKEUP_FROM_HALT_MODE    = 14'h101F;   // Same plus auto wake-up
    localparam logic [13:0] WAKE_AHALT    = 14'h0A00;   // Overflow and timebase one

    // ========================================================================
    // Condition code and register map
    // ========================================================================
    localparam int          CC_I_BIT      = 3;
    localparam logic [3:0]  REG_ENABLE    = 4'h0;
    localparam logic [3:0]  REG_SENSE     = 4'h1;
    localparam logic [3:0]  REG_PENDING   = 4'h2;
    localparam logic [3:0]  REG_STATUS    = 4'h3;
    localparam logic [13:0] ENABLE_RST    = 14'h0000;
    localparam logic [7:0]  SENSE_RST     = 8'h00;

    // ========================================================================
    // External sensitivity codes
    // ========================================================================
    localparam logic [1:0]  SENS_FALL_LOW = 2'h0;
    localparam logic [1:0]  SENS_RISE     = 2'h1;
    localparam logic [1:0]  SENS_FALL     = 2'h2;
    localparam logic [1:0]  SENS_BOTH     = 2'h3;

    // Power modes reported by the core
    typedef enum logic [2:0] {
        CIC_RUN   = 3'b000,
        CIC_WAIT  = 3'b001,
        CIC_HALT  = 3'b010,
        CIC_AHALT = 3'b011,
        CIC_WAKEUP_FROM_HALT_MODE = 3'b100
    } cic_mode_t;

    // Entry sequencer states
    typedef enum logic [3:0] {
        CIC_IDLE    = 4'b0000,
        CIC_PUSH_PL = 4'b0001,
        CIC_PUSH_PH = 4'b0010,
        CIC_PUSH_X  = 4'b0011,
        CIC_PUSH_A  = 4'b0100,
        CIC_PUSH_CC = 4'b0101,
        CIC_VEC_HI  = 4'b0110,
        CIC_VEC_LO  = 4'b0111,
        CIC_GET_LO  = 4'b1000,
        CIC_LOAD    = 4'b1001
    } cic_fsm_t;

endpackage : cic_pkg

// [cic_vec_model.sv]
// Core-side vector memory model for the interrupt controller bench
`timescale 1ns/1ps
`default_nettype none
module cic_vec_model (
    // Clock
    input  wire logic        clk_sys,
    // Vector fetch
    input  wire logic        vec_rd,
    input  wire logic [15:0] vec_addr,
    output logic      [7:0]  vec_rdata
);
    initial vec_rdata = 8'h3C;
    // Byte answers one cycle after the fetch; toggles otherwise so late samples fail
    always @(posedge clk_sys)
    begin
        if (vec_rd)
            vec_rdata <= vec_addr[7:0] ^ 8'hA5;
        else
            vec_rdata <= ~vec_rdata;
    end
endmodule : cic_vec_model
`default_nettype wire

// [cic_top_monitor.sv]
// Concurrent checks on the interrupt controller ports
`timescale 1ns/1ps
`default_nettype none
module cic_top_monitor (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        nrst,
    // Core side
    input wire logic        instr_end,
    input wire logic        trap_exec,
    input wire logic        interrupt_return_exec,
    input wire logic [7:0]  cc_pop,
    input wire logic        cpu_hold,
    input wire logic        global_mask,
    input wire logic        stack_push,
    input wire logic        vec_rd,
    input wire logic [15:0] vec_addr,
    input wire logic        pc_load,
    input wire logic [15:0] pc_value
);
    // ========================================
    // Entry and return sequence
    // ========================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    AST_RESET: assert property ($rose(nrst) |-> global_mask && !cpu_hold)
        else $error("mask clear after reset");
    AST_TRAP: assert property (instr_end && trap_exec && !cpu_hold
        |=> cpu_hold && global_mask)
        else $error("trap not entered");
    AST_PUSH: assert property ($rose(cpu_hold) |=> stack_push [*5] ##1 !stack_push)
        else $error("push count wrong");
    AST_VEC: assert property ($rose(cpu_hold) |-> ##6 vec_rd ##1
        vec_rd && vec_addr == $past(vec_addr) + 16'h0001)
        else $error("vector fetch wrong");
    AST_LOAD: assert property ($rose(cpu_hold) |-> ##9 pc_load && !cpu_hold)
        else $error("handler load late");
    AST_MASK_HOLD: assert property (cpu_hold |-> global_mask)
        else $error("mask clear in entry");
    // Masked boundary without a trap must leave the core running
    AST_MASKED: assert property (instr_end && !cpu_hold && global_mask && !trap_exec
        |=> !cpu_hold)
        else $error("masked entry");
    AST_INTERRUPT_RETURN: assert property (interrupt_return_exec && !cpu_hold
        |=> global_mask == $past(cc_pop[cic_pkg::CC_I_BIT]))
        else $error("return mask wrong");
    COV_TRAP: cover property (instr_end && trap_exec && !cpu_hold);
    COV_LOAD: cover property (pc_load && pc_value != 16'h0000);
    COV_INTERRUPT_RETURN: cover property (interrupt_return_exec);
endmodule : cic_top_monitor
bind cic_top cic_top_monitor u_mon (.clk_sys, .nrst, .instr_end, .trap_exec, .interrupt_return_exec,
    .cc_pop, .cpu_hold, .global_mask, .stack_push, .vec_rd, .vec_addr, .pc_load, .pc_value);
`default_nettype wire

// [tb_cpu_interrupt_controller.sv]
// Self-checking testbench of the CPU interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_interrupt_controller;
    // ========================================
    // Signals
    // ========================================
    logic        clk_sys, nrst, reg_wr, reg_rd, instr_end, trap_exec, interrupt_return_exec;
    logic        mask_set, mask_clr, cpu_hold, global_mask, wake_req, stack_push;
    logic        vec_rd, pc_load, supply_monitor_flag;
    logic [2:0]  power_mode;
    logic [3:0]  reg_addr, external_irq_line;
    logic [7:0]  cc_pop, cpu_x, cpu_a, cpu_cc, stack_data, vec_rdata;
    logic [13:0] periph_flag, periph_clr;
    logic [15:0] reg_wdata, reg_rdata, cpu_pc, vec_addr, pc_value, va_prev, va_last, d;
    logic [7:0]  pushed[$];
    logic [31:0] seed;
    int          failures, tests_run;
    cic_pkg::cic_mode_t wake_modes [4] = '{cic_pkg::CIC_HALT, cic_pkg::CIC_WAIT,
                                           cic_pkg::CIC_AHALT, cic_pkg::CIC_WAKEUP_FROM_HALT_MODE};

    cic_top dut (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .instr_end, .trap_exec, .interrupt_return_exec, .cc_pop, .mask_set, .mask_clr, .power_mode,
        .cpu_pc, .cpu_x, .cpu_a, .cpu_cc, .cpu_hold, .global_mask, .wake_req, .stack_push,
        .stack_data, .vec_rd, .vec_addr, .vec_rdata, .pc_load, .pc_value,
        .external_irq_line, .supply_monitor_flag, .periph_flag, .periph_clr);
    cic_vec_model core (.clk_sys, .vec_rd, .vec_addr, .vec_rdata);

    // Clock at 200 MHz
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Pushed bytes and the last two vector fetch addresses
    always @(posedge clk_sys)
    begin
        if (stack_push) pushed.push_back(stack_data);
        if (vec_rd) {va_prev, va_last} <= {va_last, vec_addr};
    end

    // ========================================
    // Helpers
    // ========================================
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Same fixed table as the vector memory model
    function automatic logic [7:0] vrom(input logic [15:0] a);
        return a[7:0] ^ 8'hA5;
    endfunction : vrom

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, exp);
    endtask : rd

    // One-cycle core command {instr_end, trap_exec, interrupt_return_exec, mask_set, mask_clr}
    task automatic step(input logic [4:0] p);
        @(posedge clk_sys);
        {instr_end, trap_exec, interrupt_return_exec, mask_set, mask_clr} <= p;
        {cpu_pc, cpu_x, cpu_a} <= rnd();
        cpu_cc <= 8'(rnd());
        cc_pop <= 8'(rnd()) & ~(8'h01 << cic_pkg::CC_I_BIT);
        @(posedge clk_sys);
        {instr_end, trap_exec, interrupt_return_exec, mask_set, mask_clr} <= 5'h00;
    endtask : step

    task automatic clr(input int n);
        @(posedge clk_sys);
        periph_clr <= 14'h0001 << n;
        @(posedge clk_sys);
        periph_clr <= 14'h0000;
    endtask : clr

    // Entry at a boundary; context, vector fetch and handler address compared
    task automatic enter(input logic t, input logic [15:0] v);
        logic [7:0] e [5];
        logic       m;
        int         n;
        n = 0;
        pushed.delete();
        @(negedge clk_sys);
        m = global_mask;
        step({1'b1, t, 3'h0});
        e = '{cpu_pc[7:0], cpu_pc[15:8], cpu_x, cpu_a, cpu_cc};
        e[4][cic_pkg::CC_I_BIT] = m;
        while (pc_load !== 1'b1 && n < 20)
        begin
            @(negedge clk_sys);
            n++;
        end
        chk(pc_value, {vrom(v), vrom(v + 16'h0001)});
        chk(va_prev, v);
        chk(16'(pushed.size()), 16'h0005);
        for (int i = 0; i < 5; i++) chk({8'h00, pushed[i]}, {8'h00, e[i]});
    endtask : enter

    task automatic noenter();
        step(5'h10);
        repeat (3) @(negedge clk_sys);
        chk({15'h0000, cpu_hold}, 16'h0000);
    endtask : noenter

    task automatic conclude();
        $display("counts: %0d compared, %0d mismatched", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    // Watchdog well beyond the expected run
    initial
    begin
        #100000;
        failures++;
        conclude();
    end

    // ========================================
    // Main sequence
    // ========================================
    initial
    begin
        {seed, failures, tests_run, nrst} = {32'h9A25, 64'h0, 1'b0};
        {reg_wr, reg_rd, instr_end, trap_exec, interrupt_return_exec, mask_set, mask_clr} = 7'h00;
        {reg_addr, reg_wdata, cpu_pc, cpu_x, cpu_a, cpu_cc, cc_pop} = '0;
        {power_mode, external_irq_line, supply_monitor_flag} = {3'h0, 4'hF, 1'b0};
        {periph_flag, periph_clr} = 28'h0;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        chk({15'h0000, global_mask}, 16'h0001);
        rd(cic_pkg::REG_ENABLE, 16'(cic_pkg::ENABLE_RST));
        d = 16'(rnd());
        wr(cic_pkg::REG_ENABLE, d);
        d = d & (16'(cic_pkg::PER_MASK) | (16'h0001 << cic_pkg::VEC_SUPPLY));
        rd(cic_pkg::REG_ENABLE, d);
        rd(4'hC, 16'h0000);
        // Line 1 falling edge only; accepted because the mask is still set
        wr(cic_pkg::REG_SENSE, 16'h0008);
        rd(cic_pkg::REG_SENSE, 16'h0008);
        $display("test registers done");
        wr(cic_pkg::REG_ENABLE, 16'h0121);
        @(posedge clk_sys);
        periph_flag <= 14'h0021;
        noenter();
        enter(1'b1, cic_pkg::TRAP_VEC);
        rd(cic_pkg::REG_STATUS, 16'h0101);
        step(5'h04);
        @(negedge clk_sys);
        chk({15'h0000, global_mask}, 16'h0000);
        enter(1'b0, cic_pkg::VEC0_ADDR);
        clr(0);
        step(5'h04);
        enter(1'b0, cic_pkg::VEC0_ADDR - 16'h000A);
        clr(5);
        step(5'h04);
        $display("test priority done");
        wr(cic_pkg::REG_ENABLE, 16'h0021);
        @(posedge clk_sys);
        periph_flag <= 14'h0121;
        clr(8);
        wr(cic_pkg::REG_ENABLE, 16'h0121);
        noenter();
        @(posedge clk_sys);
        external_irq_line <= 4'hD;
        enter(1'b0, cic_pkg::VEC0_ADDR - 16'h0004);
        step(5'h04);
        noenter();
        // Supply rise with its enable set enters vector 7 once
        wr(cic_pkg::REG_ENABLE, 16'h0080);
        @(posedge clk_sys);
        supply_monitor_flag <= 1'b1;
        enter(1'b0, cic_pkg::VEC0_ADDR - 16'h000E);
        step(5'h04);
        noenter();
        $display("test clearing done");
        step(5'h02);
        @(posedge clk_sys);
        {periph_flag, external_irq_line} <= {14'h0000, 4'hF};
        wr(cic_pkg::REG_ENABLE, 16'h0321);
        @(posedge clk_sys);
        periph_flag <= 14'h0221;
        rd(cic_pkg::REG_PENDING, 16'h0221);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys);
            power_mode <= wake_modes[i];
            repeat (2) @(negedge clk_sys);
            chk({15'h0000, wake_req}, {15'h0000, i > 0});
        end
        $display("test wake-up done");
        conclude();
    end
endmodule : tb_cpu_interrupt_controller
`default_nettype wire
